// ### fdm_pkg.sv
/*
 package for the fault diagnostic monitor: field layouts, codes, timing counts.
 assumes a single 50 MHz core clock and a synchronous active-low reset.
*/
package fdm_pkg;
   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_MHZ = 50;
   localparam int OSC_WIN_US = 20; // oscillator compare window
   localparam int OSC_WIN_CYC = OSC_WIN_US * CLK_MHZ;
   localparam int OSC_TOL = 4; // allowed tick count mismatch
   // ****************************************
   // register signature layout
   // ****************************************
   localparam int REG_W = 16;
   localparam int ADDR_W = 9;
   localparam logic [2:0] PAGE_MEAS = 3'h1; // measurement results
   localparam logic [2:0] PAGE_CFG = 3'h2; // configuration, signed
   localparam logic [2:0] PAGE_CMD = 3'h3; // commands
   localparam logic [15:0] MISR_SEED = 16'hFFFF;
   localparam logic [15:0] MISR_POLY = 16'h1021;
   localparam int NUM_TEMP = 4;
   localparam int NUM_GPIO = 2;
   localparam int NUM_MUX = NUM_TEMP + NUM_GPIO;
   localparam int ADC_W = 14;
   // ****************************************
   // fault flag bit positions
   // ****************************************
   localparam int FB_REF = 0;
   localparam int FB_REG = 1;
   localparam int FB_OSC = 2;
   localparam int FB_MUX = 3;
   localparam int FB_CFG = 4;
   localparam int FB_NVM = 5;
   localparam int NUM_FLAGS = 6;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [REG_W-1:0] data;
   } fdm_reg_word_t;

   typedef struct packed {
      logic [ADC_W-1:0] result;
      logic [ADC_W-1:0] lo;
      logic [ADC_W-1:0] hi;
   } fdm_mux_chk_t;
endpackage : fdm_pkg

// ### fdm_monitor.sv
/*
 fault diagnostic monitor: power-good, oscillator, mux self test, checksums.
 assumes inputs from comparators and the slow oscillator are asynchronous,
 scan engine strobes and register streams come from core-clock logic.
*/
`timescale 1ns/1ps
module fdm_monitor
   import fdm_pkg::*;
#(
   parameter int OSC_WIN = OSC_WIN_CYC
)(
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire logic i_pg_supply_3v3_rail,
   input wire logic i_pg_supply_2v5_rail,
   input wire logic i_pg_vcc,
   input wire logic i_pg_vref,
   input wire logic i_osc_b,
   input wire logic i_timer_tick,
   input wire logic i_temp_scan,
   input wire logic i_any_scan,
   input wire logic i_scan_continuous,
   input wire logic i_temp_mux_test_bit,
   input wire logic i_mux_valid,
   input wire logic [2:0] i_mux_idx,
   input wire fdm_mux_chk_t i_mux_chk,
   input wire logic i_mux_done,
   input wire logic i_cfg_word_valid,
   input wire fdm_reg_word_t i_cfg_word,
   input wire logic i_cfg_last,
   input wire logic i_calc_cmd,
   input wire logic i_check_cmd,
   input wire logic [REG_W-1:0] i_nvm_calc_sig,
   input wire logic [REG_W-1:0] i_nvm_factory_sig,
   input wire logic i_nvm_sig_valid,
   input wire logic i_read_cmd,
   input wire logic [NUM_FLAGS-1:0] i_clear,
   output logic o_fault_n,
   output logic [NUM_FLAGS-1:0] o_fault_status,
   output logic o_fault_response,
   output logic o_prepend_pending,
   output logic o_mux_test_drive,
   output logic [NUM_MUX-1:0] o_mux_ch_fail,
   output logic [REG_W-1:0] o_cfg_sig_stored,
   output logic [REG_W-1:0] o_cfg_sig_calc
);
   // ****************************************
   // input synchronisers
   // ****************************************
   logic [5:0] sync1;
   logic [5:0] sync2;
   wire [5:0] raw_in = {i_osc_b, i_timer_tick, i_pg_supply_3v3_rail,
      i_pg_supply_2v5_rail, i_pg_vcc, i_pg_vref};
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rstn)
      begin
         sync1 <= 6'h3F;
         sync2 <= 6'h3F;
      end
      else
      begin
         sync1 <= raw_in;
         sync2 <= sync1;
      end
   end

   // ****************************************
   // power-good and oscillator checks
   // ****************************************
   // the internal oscillator is the core clock; osc_b and timer are compared
   wire ref_bad = !sync2[0];
   wire reg_bad = !(sync2[1] & sync2[2] & sync2[3]);
   logic osc_q;
   logic tmr_q;
   logic [15:0] win_cnt;
   logic [15:0] osc_cnt;
   logic [15:0] tmr_cnt;
   wire osc_edge = sync2[5] & !osc_q;
   wire tmr_edge = sync2[4] & !tmr_q;
   wire win_end = (win_cnt == 16'(OSC_WIN - 1));
   wire [15:0] cnt_diff = (osc_cnt > tmr_cnt) ? osc_cnt - tmr_cnt : tmr_cnt - osc_cnt;
   // a dead oscillator shows as zero osc_b ticks in the window; a dead timer only shows as a count mismatch
   wire osc_bad = win_end & ((cnt_diff > 16'(OSC_TOL)) | (osc_cnt == 16'h0));
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rstn)
      begin
         osc_q <= 1'b1;
         tmr_q <= 1'b1;
         win_cnt <= 16'h0;
         osc_cnt <= 16'h0;
         tmr_cnt <= 16'h0;
      end
      else
      begin
         osc_q <= sync2[5];
         tmr_q <= sync2[4];
         win_cnt <= win_end ? 16'h0 : win_cnt + 16'h1;
         osc_cnt <= win_end ? 16'h0 : osc_cnt + 16'(osc_edge);
         tmr_cnt <= win_end ? 16'h0 : tmr_cnt + 16'(tmr_edge);
      end
   end

   // ****************************************
   // temperature mux self test
   // ****************************************
   // test voltages applied while a temperature scan runs
   logic mux_active;
   logic mux_err;
   wire mux_out = (i_mux_chk.result < i_mux_chk.lo) | (i_mux_chk.result > i_mux_chk.hi);
   wire mux_chk = mux_active & i_mux_valid & (i_mux_idx < 3'(NUM_MUX));
   wire mux_bad = mux_active & i_mux_done & (mux_err | (mux_chk & mux_out));
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rstn)
      begin
         mux_active <= 1'b0;
         mux_err <= 1'b0;
      end
      else if (i_temp_scan)
      begin
         mux_active <= 1'b1;
         mux_err <= 1'b0;
      end
      else if (i_mux_done)
         mux_active <= 1'b0;
      else if (mux_chk & mux_out)
         mux_err <= 1'b1;
   end
   // per channel failure record, kept until the next temperature scan
   genvar g;
   generate
      for (g = 0; g < NUM_MUX; g++)
      begin : g_mux
         always_ff @(posedge i_ref_clk)
         begin
            if (!i_rstn || i_temp_scan)
               o_mux_ch_fail[g] <= 1'b0;
            else if (mux_chk && i_mux_idx == 3'(g) && mux_out)
               o_mux_ch_fail[g] <= 1'b1;
         end
      end
   endgenerate

   // ****************************************
   // configuration signature (page 2 misr)
   // ****************************************
   logic [REG_W-1:0] misr;
   logic misr_busy;
   logic misr_is_check;
   wire cfg_take = misr_busy & i_cfg_word_valid & (i_cfg_word.addr[8:6] == PAGE_CFG);
   wire [REG_W-1:0] misr_shift = {misr[REG_W-2:0], 1'b0} ^ (misr[REG_W-1] ? MISR_POLY : 16'h0);
   wire [REG_W-1:0] misr_next = cfg_take ? (misr_shift ^ i_cfg_word.data) : misr;
   wire misr_end = misr_busy & i_cfg_last;
   wire cfg_bad = misr_end & misr_is_check & (misr_next != o_cfg_sig_stored);
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rstn)
      begin
         misr <= MISR_SEED;
         misr_busy <= 1'b0;
         misr_is_check <= 1'b0;
         o_cfg_sig_stored <= MISR_SEED;
         o_cfg_sig_calc <= MISR_SEED;
      end
      else if (i_calc_cmd | i_check_cmd)
      begin
         misr <= MISR_SEED;
         misr_busy <= 1'b1;
         misr_is_check <= i_check_cmd;
      end
      else if (misr_end)
      begin
         misr_busy <= 1'b0;
         o_cfg_sig_calc <= misr_next;
         if (!misr_is_check)
            o_cfg_sig_stored <= misr_next;
      end
      else
         misr <= misr_next;
   end

   // ****************************************
   // nvm signature and flag latch
   // ****************************************
   wire nvm_bad = i_any_scan & i_nvm_sig_valid & (i_nvm_calc_sig != i_nvm_factory_sig);
   wire [NUM_FLAGS-1:0] fault_set = {nvm_bad, cfg_bad, mux_bad, osc_bad, reg_bad, ref_bad};
   // set beats clear, flags stick until host clears
   wire [NUM_FLAGS-1:0] next_status = fault_set | (o_fault_status & ~i_clear);
   wire new_fault = |(fault_set & ~o_fault_status);
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rstn)
      begin
         o_fault_status <= '0;
         o_fault_n <= 1'b1;
         o_fault_response <= 1'b0;
         o_prepend_pending <= 1'b0;
         o_mux_test_drive <= 1'b0;
      end
      else
      begin
         o_fault_status <= next_status;
         o_fault_n <= ~(|next_status);
         o_fault_response <= new_fault & i_scan_continuous;
         if (new_fault & !i_scan_continuous)
            o_prepend_pending <= 1'b1;
         else if (i_read_cmd)
            o_prepend_pending <= 1'b0;
         o_mux_test_drive <= (mux_active | i_temp_scan) & ~i_mux_done;
      end
   end
   // host side, no logic here

   // ****************************************
   // assertions
   // ****************************************
   property p_pin;
      @(posedge i_ref_clk) disable iff (!i_rstn) (|fault_set) |=> !o_fault_n;
   endproperty
   a_pin: assert property (p_pin) else $error("fault pin not low");
   property p_ref;
      @(posedge i_ref_clk) disable iff (!i_rstn) ##2 !$past(i_pg_vref, 2) |=> o_fault_status[FB_REF];
   endproperty
   a_ref: assert property (p_ref) else $error("reference flag missing");
   property p_osc;
      @(posedge i_ref_clk) disable iff (!i_rstn) osc_bad |=> o_fault_status[FB_OSC];
   endproperty
   a_osc: assert property (p_osc) else $error("oscillator flag missing");
   property p_cont;
      @(posedge i_ref_clk) disable iff (!i_rstn)
         (new_fault && i_scan_continuous) |=> o_fault_response;
   endproperty
   a_cont: assert property (p_cont) else $error("no immediate response");
   property p_prep;
      @(posedge i_ref_clk) disable iff (!i_rstn)
         (new_fault && !i_scan_continuous) |=> o_prepend_pending && !o_fault_response;
   endproperty
   a_prep: assert property (p_prep) else $error("response not deferred");
   property p_mux;
      @(posedge i_ref_clk) disable iff (!i_rstn)
         (mux_active && i_mux_done && mux_err) |=> o_fault_status[FB_MUX];
   endproperty
   a_mux: assert property (p_mux) else $error("mux flag missing");
   property p_cfg;
      @(posedge i_ref_clk) disable iff (!i_rstn) cfg_bad |=> o_fault_status[FB_CFG];
   endproperty
   a_cfg: assert property (p_cfg) else $error("checksum flag missing");
   property p_nvm;
      @(posedge i_ref_clk) disable iff (!i_rstn)
         (i_any_scan && i_nvm_sig_valid && i_nvm_calc_sig != i_nvm_factory_sig)
         |=> o_fault_status[FB_NVM];
   endproperty
   a_nvm: assert property (p_nvm) else $error("nvm flag missing");
   property p_hold;
      @(posedge i_ref_clk) disable iff (!i_rstn)
         (o_fault_status[FB_CFG] && !i_clear[FB_CFG]) |=> o_fault_status[FB_CFG];
   endproperty
   a_hold: assert property (p_hold) else $error("flag dropped early");
   property p_pg14;
      @(posedge i_ref_clk) disable iff (!i_rstn)
         (misr_busy && i_cfg_word_valid && i_cfg_word.addr[8:6] != PAGE_CFG && !i_cfg_last
         && !i_calc_cmd && !i_check_cmd) |=> $stable(misr);
   endproperty
   a_pg14: assert property (p_pg14) else $error("non page 2 word signed");
   c_cont: cover property (@(posedge i_ref_clk) new_fault && i_scan_continuous);
   c_cfg: cover property (@(posedge i_ref_clk) cfg_bad);
   c_mux: cover property (@(posedge i_ref_clk) mux_bad);
   c_clr: cover property (@(posedge i_ref_clk) o_fault_status[FB_NVM] ##1 !o_fault_status[FB_NVM]);
endmodule : fdm_monitor

// ### fdm_host_model.sv
/*
 host controller model: turns op codes into one-cycle command pulses.
 assumes each op is held for one core clock cycle.
*/
`timescale 1ns/1ps
module fdm_host_model
   import fdm_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic [2:0] i_op,
   input wire logic [REG_W-1:0] i_nvm_calc_sig,
   input wire logic [REG_W-1:0] i_nvm_factory_sig,
   output logic o_calc,
   output logic o_check,
   output logic o_scan,
   output logic o_temp_scan,
   output logic o_read,
   output logic o_nvm_match
);
   // ****************************************
   // command pulses
   // ****************************************
   // op 1 calc, 2 check, 3 scan, 4 temp scan, 5 read
   always_ff @(posedge i_ref_clk)
   begin
      o_calc <= (i_op == 3'h1);
      o_check <= (i_op == 3'h2);
      o_scan <= (i_op == 3'h3);
      o_temp_scan <= (i_op == 3'h4);
      o_read <= (i_op == 3'h5);
   end
   // host side comparison of the two nvm signatures
   assign o_nvm_match = (i_nvm_calc_sig === i_nvm_factory_sig);
endmodule : fdm_host_model

// ### fdm_monitor_tb.sv
/*
 self-checking bench for the fault monitor, driven through a host model.
 assumes a shortened oscillator window of 50 cycles.
*/
`timescale 1ns/1ps
module fdm_monitor_tb
   import fdm_pkg::*;
;
   // ****************************************
   // stimulus and observation
   // ****************************************
   logic clk = 1'b0, rstn = 1'b0, osc = 1'b0, osc_en = 1'b1, cont = 1'b0;
   logic tmr = 1'b0, tmr_en = 1'b1;
   logic [5:0] wmask = 6'h00; // which stream words carry valid
   logic tbit = 1'b0, mv = 1'b0, md = 1'b0, wv = 1'b0, wl = 1'b0, nval = 1'b0;
   logic [3:0] pg = 4'hF; // 3v3, 2v5, vcc, vref
   logic [2:0] midx = 3'h0, op = 3'h0;
   logic [5:0] clr = 6'h00, st, chf, e, last_st = 6'h00;
   fdm_mux_chk_t mchk = '0;
   fdm_reg_word_t wd = '0;
   logic [15:0] nc = 16'h0000, nf = 16'h0000, sst, scalc, sig, d, r;
   logic [15:0] last_sig = 16'hFFFF;
   logic calc, chkc, scan, tscan, rd, nmatch, fn, resp, pend, drv;
   logic [15:0] wds [6];
   logic [5:0] q_st [$];
   logic [15:0] q_sig [$];
   int err_total = 0, n_tests = 0, n_resp = 0;
   integer seed = 32'hEAD19BB1;

   always #10 clk = ~clk;
   // second oscillator and timer, each stoppable on its own
   always @(posedge clk) if (osc_en) osc <= ~osc;
   always @(posedge clk) if (tmr_en) tmr <= ~tmr;

   fdm_monitor #(.OSC_WIN(50)) fdm_monitor_inst (.i_ref_clk(clk), .i_rstn(rstn),
      .i_pg_supply_3v3_rail(pg[3]), .i_pg_supply_2v5_rail(pg[2]), .i_pg_vcc(pg[1]),
      .i_pg_vref(pg[0]), .i_osc_b(osc), .i_timer_tick(tmr), .i_temp_scan(tscan),
      .i_any_scan(scan), .i_scan_continuous(cont), .i_temp_mux_test_bit(tbit),
      .i_mux_valid(mv), .i_mux_idx(midx), .i_mux_chk(mchk), .i_mux_done(md),
      .i_cfg_word_valid(wv), .i_cfg_word(wd), .i_cfg_last(wl), .i_calc_cmd(calc),
      .i_check_cmd(chkc), .i_nvm_calc_sig(nc), .i_nvm_factory_sig(nf),
      .i_nvm_sig_valid(nval), .i_read_cmd(rd), .i_clear(clr), .o_fault_n(fn),
      .o_fault_status(st), .o_fault_response(resp), .o_prepend_pending(pend),
      .o_mux_test_drive(drv), .o_mux_ch_fail(chf), .o_cfg_sig_stored(sst),
      .o_cfg_sig_calc(scalc));
   fdm_host_model fdm_host_model_inst (.i_ref_clk(clk), .i_op(op), .i_nvm_calc_sig(nc),
      .i_nvm_factory_sig(nf), .o_calc(calc), .o_check(chkc), .o_scan(scan),
      .o_temp_scan(tscan), .o_read(rd), .o_nvm_match(nmatch));

   task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_total++;
         $display("mismatch %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic cyc(int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task automatic cmd(logic [2:0] v);
      op <= v;
      cyc(1);
      op <= 3'h0;
      cyc(1);
   endtask : cmd
   task automatic clear(logic [5:0] m);
      q_st.push_back(6'h00);
      clr <= m;
      cyc(1);
      clr <= 6'h00;
      cyc(2);
   endtask : clear
   // word stream: page 1 and page 3 words mixed in must be ignored
   task automatic cfg_run(logic [2:0] c, logic [15:0] flip);
      cmd(c);
      sig = MISR_SEED;
      for (int i = 0; i < 6; i++)
      begin
         d = wds[i] ^ ((i == 2) ? flip : 16'h0000);
         wv <= wmask[i] | (i == 2) | (i == 5);
         wl <= (i == 5);
         wd <= '{addr: {(i == 1) ? PAGE_MEAS : (i == 3) ? PAGE_CMD : PAGE_CFG, 6'(i)}, data: d};
         if ((wmask[i] || i == 2 || i == 5) && i != 1 && i != 3)
            sig = {sig[14:0], 1'b0} ^ (sig[15] ? MISR_POLY : 16'h0000) ^ d;
         cyc(1);
      end
      if (c == 3'h1) q_sig.push_back(sig);
      wv <= 1'b0;
      wl <= 1'b0;
      cyc(3);
   endtask : cfg_run
   task automatic stop_test();
      $display("checks %0d errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : stop_test

   // watcher: each status or signature change takes the oldest note
   always @(posedge clk)
   begin
      if (resp === 1'b1) n_resp++;
      if (rstn && st !== last_st)
      begin
         last_st <= st;
         e = (q_st.size() > 0) ? q_st.pop_front() : 6'h3F;
         chk("status", st, e);
         chk("fault_n", fn, (e == 6'h00));
      end
      if (rstn && sst !== last_sig)
      begin
         last_sig <= sst;
         chk("sig_stored", sst, (q_sig.size() > 0) ? q_sig.pop_front() : 16'h0000);
      end
   end

   // main sequence
   initial
   begin
      for (int i = 0; i < 6; i++) wds[i] = 16'($random(seed));
      wmask = 6'($random(seed));
      cyc(16);
      rstn <= 1'b1;
      cyc(2);
      cont <= 1'b1;
      q_st.push_back(6'h01);
      pg <= 4'hE;
      cyc(8);
      cont <= 1'b0;
      pg <= 4'hF;
      cyc(4);
      clear(6'h01);
      for (int b = 1; b < 4; b++)
      begin
         q_st.push_back(6'h02);
         pg <= 4'hF & ~(4'h1 << b);
         cyc(8);
         chk("pending", pend, 1);
         cmd(3'h5);
         cyc(1);
         chk("pending", pend, 0);
         pg <= 4'hF;
         cyc(4);
         clear(6'h02);
      end
      // first a dead timer, then a dead second oscillator
      for (int k = 0; k < 2; k++)
      begin
         q_st.push_back(6'h04);
         if (k == 0)
            tmr_en <= 1'b0;
         else
            osc_en <= 1'b0;
         cyc(200);
         tmr_en <= 1'b1;
         osc_en <= 1'b1;
         cyc(200);
         clear(6'h04);
      end
      tbit <= 1'b1;
      cmd(3'h4);
      cyc(2);
      chk("mux_drive", drv, 1);
      q_st.push_back(6'h08);
      for (int i = 0; i < 8; i++)
      begin
         mv <= (i == 2) | 1'($random(seed));
         midx <= 3'(i);
         mchk <= '{result: (i == 2 || i > 5) ? 14'h0300 : 14'h0100, lo: 14'h0050, hi: 14'h0200};
         cyc(1);
      end
      mv <= 1'b0;
      md <= 1'b1;
      cyc(1);
      md <= 1'b0;
      tbit <= 1'b0;
      cyc(3);
      chk("mux_ch", chf, 6'h04);
      chk("mux_drive", drv, 0);
      clear(6'h08);
      cfg_run(3'h1, 16'h0000);
      cfg_run(3'h2, 16'h0000);
      chk("sig_calc", scalc, sig);
      q_st.push_back(6'h10);
      cfg_run(3'h2, 16'h0001);
      chk("sig_calc", scalc, sig);
      clear(6'h10);
      r = 16'($random(seed));
      nval <= 1'b1;
      nc <= r;
      nf <= r;
      cmd(3'h3);
      cyc(3);
      chk("nvm_match", nmatch, 1);
      q_st.push_back(6'h20);
      nf <= r ^ 16'h8000;
      cyc(1);
      chk("nvm_match", nmatch, 0);
      cmd(3'h3);
      cyc(3);
      clear(6'h20);
      nval <= 1'b0;
      cyc(5);
      chk("responses", 16'(n_resp), 1);
      chk("notes_left", 16'(q_st.size() + q_sig.size()), 0);
      stop_test();
   end

   // watchdog against a hang
   initial
   begin
      cyc(20000);
      err_total++;
      stop_test();
   end
endmodule : fdm_monitor_tb
